// file: dv/uart_shadow_peer.sv
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_peer
    import uart_shadow_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic stall_i,
    input wire logic tx_valid_i,
    input wire data_byte_t tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output data_byte_t rx_data_o
);
    data_byte_t got[$];
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    assign tx_ready_o = !stall_i;
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
    end
    task send(input data_byte_t b);
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        // Stale byte must not look valid, so show its inverse
        rx_data_o <= ~b;
    endtask : send
endmodule : uart_shadow_peer
`default_nettype wire

// file: dv/uart_shadow_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_defines.svh"
module uart_shadow_props
    import uart_shadow_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire htrans_t htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire data_byte_t tx_data_o
);
    logic acc, hit, mapped, adph, wdph, next_adph, next_wdph;
    assign acc = hsel_i & hready_i & htrans_i[1];
    assign hit = (haddr_i - `ALIAS_BASE_ADDR) < 32'h0000_0040;
    assign mapped = hit | (haddr_i >= `CTRL_ADDR && haddr_i <= `IRQ_ENABLE_ADDR);
    always_comb begin
        next_adph = acc & hwrite_i;
        next_wdph = next_adph & hit;
    end
    // Remembers a write data phase, which may legally change the pending byte
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adph <= 1'b0;
            wdph <= 1'b0;
        end else begin
            adph <= next_adph;
            wdph <= next_wdph;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wr;
        acc && hwrite_i && hit;
    endsequence
    sequence s_idle_tx;
        tx_valid_o && !tx_ready_i && !adph;
    endsequence
    AST_WR_PENDS: assert property (s_wr |-> ##2 tx_valid_o)
        else $error("alias write left no pending byte");
    AST_WR_DATA: assert property (s_wr ##1 !tx_valid_o |=> tx_data_o == $past(hwdata_i[7:0]))
        else $error("pending byte differs from written byte");
    AST_HOLD_VALID: assert property (s_idle_tx |=> tx_valid_o)
        else $error("pending byte dropped without hand-off");
    AST_HOLD_DATA: assert property (s_idle_tx |=> $stable(tx_data_o))
        else $error("pending byte changed without a write");
    AST_ROSE_FROM_WR: assert property ($rose(tx_valid_o) |-> $past(wdph))
        else $error("pending byte appeared without alias write");
    AST_ZERO_WAIT: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    AST_RD_BYTE: assert property (acc && !hwrite_i && hit |=> hrdata_o[31:8] == 24'h00_0000)
        else $error("alias read has upper bits set");
    AST_UNMAPPED: assert property (acc && !hwrite_i && !mapped |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : uart_shadow_props
bind uart_shadow_port uart_shadow_props i_props(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o));
`default_nettype wire

// file: dv/uart_shadow_rx_tx_buffer_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_defines.svh"
module uart_shadow_rx_tx_buffer_port_bench;
    import uart_shadow_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, stall = 1'b0;
    logic hrdy, hresp, rxv, txv, txr, ir, irq;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    htrans_t htrans = 2'h0;
    data_byte_t rxd, txd;
    int errors = 0, n_compared = 0;
    localparam logic [31:0] B = `ALIAS_BASE_ADDR, ST = `STATUS_ADDR;
    uart_shadow_port i_dut(.sys_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .rx_valid_i(rxv), .rx_data_i(rxd), .tx_ready_i(txr), .tx_valid_o(txv),
        .tx_data_o(txd), .tx_ir_mode_o(ir), .irq_o(irq));
    uart_shadow_peer i_peer(.sys_clk_i(clk), .stall_i(stall), .tx_valid_i(txv),
        .tx_data_i(txd), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task summarize;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                summarize();
            end
            @(posedge clk);
        end
    endtask : rdy
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        chk(q & m, e);
    endtask : rd
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(B + 32'h0000_0010, 32'hffff_ffff, 32'h0000_0000);
        stall <= 1'b1;
        wr(B, 32'h0000_0011);
        rd(ST, 32'h0000_0020, 32'h0000_0000);
        wr(B + 32'h0000_003c, 32'h0000_0022);
        rd(`IRQ_STATUS_ADDR, 32'h0000_0004, 32'h0000_0000);
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(i_peer.got.size()), 32'h0000_0001);
        chk(32'(i_peer.got[0]), 32'h0000_0022);
        i_peer.got.delete();
        i_peer.send(8'h5a);
        i_peer.send(8'ha5);
        @(posedge clk);
        rd(ST, 32'h0000_0003, 32'h0000_0003);
        rd(B + 32'h0000_0024, 32'h0000_00ff, 32'h0000_00a5);
        rd(ST, 32'h0000_0003, 32'h0000_0000);
        wr(`CTRL_ADDR, 32'h0000_0001);
        stall <= 1'b1;
        for (int i = 0; i < 17; i++) wr(B + 32'(4 * (i % 16)), 32'h40 + i);
        rd(`IRQ_STATUS_ADDR, 32'h0000_0004, 32'h0000_0004);
        chk(32'(irq), 32'h0000_0000);
        wr(`IRQ_ENABLE_ADDR, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        wr(`IRQ_CLEAR_ADDR, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        chk(32'(i_peer.got.size()), 32'h0000_0010);
        for (int i = 0; i < 16; i++) chk(32'(i_peer.got[i]), 32'h40 + i);
        for (int i = 0; i < 17; i++) i_peer.send(8'(8'h60 + i));
        @(posedge clk);
        rd(ST, 32'h0000_0003, 32'h0000_0003);
        for (int i = 0; i < 16; i++) rd(B + 32'(4 * i), 32'h0000_00ff, 32'h60 + i);
        rd(ST, 32'h0000_0001, 32'h0000_0000);
        rd(B, 32'h0000_00ff, 32'h0000_0060);
        wr(`CTRL_ADDR, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk(32'(ir), 32'h0000_0001);
        rd(B + 32'h0000_0040, 32'hffff_ffff, 32'h0000_0000);
        summarize();
    end
endmodule : uart_shadow_rx_tx_buffer_port_bench
`default_nettype wire

// file: rtl/uart_shadow_defines.svh
`ifndef UART_SHADOW_DEFINES_SVH
`define UART_SHADOW_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (absolute byte addresses on the bus)
// ----------------------------------------------------------------
// Alias four sits at 0x50001140; the sixteen aliases span 0x...1130..0x...116C
`define ALIAS_BASE_ADDR 32'h5000_1130
`define ALIAS_FOUR_ADDR 32'h5000_1140
`define ALIAS_COUNT 5'h10
`define DATA_RESET 8'h00
// Own control/status registers placed above the alias window
`define CTRL_ADDR 32'h5000_1180
`define STATUS_ADDR 32'h5000_1184
`define IRQ_STATUS_ADDR 32'h5000_1188
`define IRQ_CLEAR_ADDR 32'h5000_118C
`define IRQ_ENABLE_ADDR 32'h5000_1190

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define STAT_DATA_READY_BIT 0
`define STAT_OVERRUN_BIT 1
`define STAT_HOLDING_EMPTY_BIT 5
`define IRQ_RX_BIT 0
`define IRQ_OVERRUN_BIT 1
`define IRQ_TX_LOST_BIT 2
`define IRQ_WIDTH 3

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4
`define FIFO_CNT_W 5

`endif

// file: rtl/uart_shadow_pkg.sv
package uart_shadow_pkg;
    typedef logic [7:0] data_byte_t;
    typedef logic [1:0] htrans_t;
endpackage : uart_shadow_pkg

// file: rtl/uart_shadow_port.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_defines.svh"

// Functional notes
// - Sixteen consecutive words all alias the same receive/transmit data port.
// - A read returns in bits 7:0 the byte received from the serial or infrared input.
// - With FIFOs off, a new byte overwrites an unread receive buffer and flags overrun.
// - With FIFOs on, a read returns the head of the receive FIFO.
// - With the receive FIFO full, a new byte is dropped, contents kept, overrun flagged.
// - With FIFOs off, writing one byte while holding-empty is set clears that flag.
// - With FIFOs off, further writes before the flag returns overwrite the held byte.
// - With FIFOs on, sixteen writes are accepted before the transmit FIFO is full.
// - A write while the transmit FIFO is full is discarded.
// - Transmit data goes to the serial output or, in infrared mode, the infrared output.
module uart_shadow_port
    import uart_shadow_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire htrans_t htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic rx_valid_i,
    input wire data_byte_t rx_data_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output data_byte_t tx_data_o,
    output logic tx_ir_mode_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function automatic logic is_alias(input logic [31:0] a);
        is_alias = (a >= `ALIAS_BASE_ADDR) &&
                   (a < `ALIAS_BASE_ADDR + {25'h0, `ALIAS_COUNT, 2'b00});
    endfunction : is_alias

    // Non-FIFO mode keeps its single byte in slot zero
    function automatic logic [`FIFO_PTR_W-1:0] slot_of(input logic fifo_on,
                                                       input logic [`FIFO_PTR_W-1:0] ptr);
        slot_of = fifo_on ? ptr : 4'h0;
    endfunction : slot_of

    logic ap_valid;
    logic dp_active, next_dp_active;
    logic dp_write, next_dp_write;
    logic [31:0] dp_addr, next_dp_addr;

    assign ap_valid = hsel_i && hready_i && htrans_i[1];

    always_comb begin
        next_dp_active = ap_valid;
        next_dp_write = hwrite_i;
        next_dp_addr = haddr_i;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dp_active <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 32'h0000_0000;
        end else begin
            dp_active <= next_dp_active;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
        end
    end

    logic wr_data, rd_data, wr_ctrl, wr_clr, wr_en;
    assign wr_data = dp_active && dp_write && is_alias(dp_addr);
    assign rd_data = ap_valid && !hwrite_i && is_alias(haddr_i);
    assign wr_ctrl = dp_active && dp_write && (dp_addr == `CTRL_ADDR);
    assign wr_clr = dp_active && dp_write && (dp_addr == `IRQ_CLEAR_ADDR);
    assign wr_en = dp_active && dp_write && (dp_addr == `IRQ_ENABLE_ADDR);

    // ----------------------------------------------------------------
    // Control, receive and transmit storage
    // ----------------------------------------------------------------
    logic fifo_en, next_fifo_en;
    logic ir_mode, next_ir_mode;
    data_byte_t rx_mem [`FIFO_DEPTH];
    data_byte_t tx_mem [`FIFO_DEPTH];
    logic [`FIFO_PTR_W-1:0] rx_rd, next_rx_rd, rx_wr, next_rx_wr;
    logic [`FIFO_CNT_W-1:0] rx_cnt, next_rx_cnt;
    logic [`FIFO_PTR_W-1:0] tx_rd, next_tx_rd, tx_wr, next_tx_wr;
    logic [`FIFO_CNT_W-1:0] tx_cnt, next_tx_cnt;
    logic overrun, next_overrun;
    logic rx_push, tx_push, tx_pop, rx_pop, rx_full, tx_full, tx_lost;
    logic rx_hold_ok;

    // Depth is one in non-FIFO mode: the single buffer sits in slot zero
    assign rx_full = fifo_en ? (rx_cnt == 5'(`FIFO_DEPTH)) : (rx_cnt != 5'h0);
    assign tx_full = fifo_en ? (tx_cnt == 5'(`FIFO_DEPTH)) : (tx_cnt != 5'h0);
    assign rx_pop = rd_data && (rx_cnt != 5'h0);
    assign rx_hold_ok = !fifo_en || !rx_full;
    assign rx_push = rx_valid_i && rx_hold_ok;
    assign tx_pop = tx_valid_o && tx_ready_i;
    assign tx_push = wr_data && (!tx_full || !fifo_en);
    // Overwriting the single holding byte is legal, so only FIFO mode can lose a write
    assign tx_lost = wr_data && fifo_en && tx_full;

    always_comb begin
        next_fifo_en = fifo_en;
        next_ir_mode = ir_mode;
        next_rx_rd = rx_rd;
        next_rx_wr = rx_wr;
        next_rx_cnt = rx_cnt;
        next_tx_rd = tx_rd;
        next_tx_wr = tx_wr;
        next_tx_cnt = tx_cnt;
        next_overrun = overrun;
        if (wr_ctrl) begin
            next_fifo_en = hwdata_i[`CTRL_FIFO_EN_BIT];
            next_ir_mode = hwdata_i[`CTRL_IR_MODE_BIT];
        end
        // Reading the status register clears the overrun flag; a new overrun wins
        if (ap_valid && !hwrite_i && haddr_i == `STATUS_ADDR) begin
            next_overrun = 1'b0;
        end
        if (rx_valid_i && rx_full) begin
            next_overrun = 1'b1;
        end
        if (fifo_en) begin
            if (rx_pop) begin
                next_rx_rd = rx_rd + 4'h1;
            end
            if (rx_push) begin
                next_rx_wr = rx_wr + 4'h1;
            end
            next_rx_cnt = rx_cnt + 5'(rx_push) - 5'(rx_pop);
            if (tx_pop) begin
                next_tx_rd = tx_rd + 4'h1;
            end
            if (tx_push) begin
                next_tx_wr = tx_wr + 4'h1;
            end
            next_tx_cnt = tx_cnt + 5'(tx_push) - 5'(tx_pop);
        end else begin
            // Single buffers: a push overwrites and leaves the byte pending
            next_rx_rd = 4'h0;
            next_rx_wr = 4'h0;
            next_tx_rd = 4'h0;
            next_tx_wr = 4'h0;
            if (rx_push) begin
                next_rx_cnt = 5'h1;
            end else if (rx_pop) begin
                next_rx_cnt = 5'h0;
            end
            if (tx_push) begin
                next_tx_cnt = 5'h1;
            end else if (tx_pop) begin
                next_tx_cnt = 5'h0;
            end
        end
        // Toggling the FIFO mode flushes both paths
        if (wr_ctrl && (hwdata_i[`CTRL_FIFO_EN_BIT] != fifo_en)) begin
            next_rx_rd = 4'h0;
            next_rx_wr = 4'h0;
            next_rx_cnt = 5'h0;
            next_tx_rd = 4'h0;
            next_tx_wr = 4'h0;
            next_tx_cnt = 5'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fifo_en <= 1'b0;
            ir_mode <= 1'b0;
            rx_rd <= 4'h0;
            rx_wr <= 4'h0;
            rx_cnt <= 5'h0;
            tx_rd <= 4'h0;
            tx_wr <= 4'h0;
            tx_cnt <= 5'h0;
            overrun <= 1'b0;
        end else begin
            fifo_en <= next_fifo_en;
            ir_mode <= next_ir_mode;
            rx_rd <= next_rx_rd;
            rx_wr <= next_rx_wr;
            rx_cnt <= next_rx_cnt;
            tx_rd <= next_tx_rd;
            tx_wr <= next_tx_wr;
            tx_cnt <= next_tx_cnt;
            overrun <= next_overrun;
        end
    end

    // Arrays take a reset so a read of a never-filled buffer shows zero, not garbage;
    // the price is reset fan-out on every byte slot
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < `FIFO_DEPTH; i++) begin
                rx_mem[i] <= `DATA_RESET;
                tx_mem[i] <= `DATA_RESET;
            end
        end else begin
            if (rx_push) begin
                rx_mem[slot_of(fifo_en, rx_wr)] <= rx_data_i;
            end
            if (tx_push) begin
                tx_mem[slot_of(fifo_en, tx_wr)] <= hwdata_i[7:0];
            end
        end
    end

    // A byte pushed into the slot that becomes the head is forwarded; otherwise the
    // output register would offer the slot's old byte for one cycle
    logic head_push;
    data_byte_t next_tx_data;

    always_comb begin
        head_push = tx_push && (!fifo_en || (next_tx_rd == tx_wr));
        if (head_push) begin
            next_tx_data = hwdata_i[7:0];
        end else begin
            next_tx_data = tx_mem[slot_of(fifo_en, next_tx_rd)];
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [`IRQ_WIDTH-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en, irq_evt;
    assign irq_evt = {tx_lost, rx_valid_i && rx_full, rx_push};

    always_comb begin
        next_irq_en = irq_en;
        next_irq_stat = irq_stat;
        if (wr_en) begin
            next_irq_en = hwdata_i[`IRQ_WIDTH-1:0];
        end
        if (wr_clr) begin
            next_irq_stat = irq_stat & ~hwdata_i[`IRQ_WIDTH-1:0];
        end
        next_irq_stat = next_irq_stat | irq_evt;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat <= 3'h0;
            irq_en <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            irq_o <= |(next_irq_stat & next_irq_en);
        end
    end

    // ----------------------------------------------------------------
    // Read data and outputs
    // ----------------------------------------------------------------
    logic [31:0] next_hrdata;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_DATA_READY_BIT] = (rx_cnt != 5'h0);
        status_word[`STAT_OVERRUN_BIT] = overrun;
        status_word[`STAT_HOLDING_EMPTY_BIT] = (tx_cnt == 5'h0);
        next_hrdata = 32'h0000_0000;
        if (ap_valid && !hwrite_i) begin
            if (is_alias(haddr_i)) begin
                next_hrdata = {24'h00_0000, rx_mem[fifo_en ? rx_rd : 4'h0]};
            end else if (haddr_i == `CTRL_ADDR) begin
                next_hrdata = {30'h0, ir_mode, fifo_en};
            end else if (haddr_i == `STATUS_ADDR) begin
                next_hrdata = status_word;
            end else if (haddr_i == `IRQ_STATUS_ADDR) begin
                next_hrdata = {29'h0, irq_stat};
            end else if (haddr_i == `IRQ_ENABLE_ADDR) begin
                next_hrdata = {29'h0, irq_en};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_data_o <= `DATA_RESET;
            tx_ir_mode_o <= 1'b0;
        end else begin
            hrdata_o <= next_hrdata;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            // A pop of the last byte alongside a push keeps the strobe up, no gap
            tx_valid_o <= (next_tx_cnt != 5'h0);
            tx_data_o <= next_tx_data;
            tx_ir_mode_o <= next_ir_mode;
        end
    end

endmodule : uart_shadow_port
`default_nettype wire
